/* File: hw/usb_endpoint_rx_control.sv */
// receive control registers of sixteen endpoints and device configuration, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_params.svh"
module usb_endpoint_rx_control #(
	parameter int NUM_EP = 16,
	parameter int FRAME_CYC = `FRAME_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic USB_BUS_RESET,
	input wire logic USB_RESUME,
	input wire logic SOF_RECEIVED,
	input wire logic TIMER_SUSPEND_FLAG,
	input wire logic RX_REQ,
	input wire usb_rx_pkg::ep_num_t RX_EP_NUM,
	input wire logic RX_SETUP,
	input wire logic RX_DATA_PID,
	input wire logic RX_ZERO_LEN,
	input wire logic RX_CRC_OK,
	output logic RX_ANS_VALID,
	output usb_rx_pkg::hs_t RX_ANS_CODE,
	output logic RX_ANS_HIT,
	output usb_rx_pkg::ep_num_t RX_ANS_SLOT,
	output logic RX_ANS_BUF_SEL,
	input wire logic USB_OE_INTERNAL,
	output logic UPSTREAM_OUTPUT_ENABLE_PIN,
	output logic UPSTREAM_OUTPUT_ENABLE_PIN_OE,
	output logic FRAME_START_PULSE_OUT,
	output logic FRAME_START_PULSE_OUT_OE,
	input wire logic LOW_VOLTAGE_DETECTOR,
	output logic DEVICE_RESET_REQ
);
	import usb_rx_pkg::*;

	localparam int FR_LEAD = `LEAD_CYC;
	localparam int FR_PULSE = `PULSE_CYC;

	// ****************************************
	// bus address and data phase
	// ****************************************
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [15:0] addr_ff;
	logic hready_ff;
	logic [31:0] hrdata_ff;
	logic take_addr;
	logic addr_ok;

	assign take_addr = HSEL && HTRANS[1] && HREADY;
	// anything above the page and index bits must be zero
	assign addr_ok = (HADDR[31:18] == 14'h0) && (HADDR[1:0] == 2'h0);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 16'h0;
			hready_ff <= 1'b1;
		end else if (CE) begin
			wr_pend_ff <= take_addr && HWRITE && addr_ok;
			if (take_addr && !HWRITE) begin
				// one wait state so a read sees the previous write
				rd_pend_ff <= 1'b1;
				hready_ff <= 1'b0;
			end else begin
				rd_pend_ff <= 1'b0;
				hready_ff <= 1'b1;
			end
			if (take_addr) begin
				addr_ff <= addr_ok ? HADDR[17:2] : 16'hffff;
			end
		end
	end

	// ****************************************
	// address decode
	// ****************************************
	logic [7:0] a_page;
	logic [7:0] a_idx;
	logic ep_sel;
	logic [3:0] ep_addr;
	logic sel_cfg1;
	logic sel_cfg2;
	logic sel_mir_a;
	logic sel_mir_b;
	logic sel_ctr;
	logic sel_cep;
	logic sel_iso;
	logic sel_ctrl;

	assign a_page = addr_ff[15:8];
	assign a_idx = addr_ff[7:0];
	assign ep_sel = (a_page == `EP_PAGE_LO || a_page == `EP_PAGE_HI)
		&& a_idx >= `EP_RX_IDX_FIRST && a_idx[0];
	assign ep_addr = {a_page == `EP_PAGE_HI, a_idx[3:1]};
	assign sel_cfg1 = a_page == `CFG_PAGE && a_idx == `DEV_CFG1_IDX;
	assign sel_cfg2 = a_page == `CFG_PAGE && a_idx == `DEV_CFG2_IDX;
	assign sel_mir_a = a_page == `CFG_PAGE && a_idx == `MIRROR_A_IDX;
	assign sel_mir_b = a_page == `CFG_PAGE && a_idx == `MIRROR_B_IDX;
	assign sel_ctr = a_page == `OWN_PAGE && a_idx == `CTR_FLAG_IDX;
	assign sel_cep = a_page == `OWN_PAGE && a_idx == `CEP_MASK_IDX;
	assign sel_iso = a_page == `OWN_PAGE && a_idx == `ISO_MASK_IDX;
	assign sel_ctrl = a_page == `OWN_PAGE && a_idx == `USB_CTRL_IDX;

	// ****************************************
	// configuration, control and mirror registers
	// ****************************************
	logic oe_en_ff;
	logic lvd_dis_ff;
	logic sof_en_ff;
	logic force_rst_ff;
	reg8_t mir_a_ff;
	reg8_t mir_b_ff;
	logic [NUM_EP-1:0] cep_ff;
	logic [NUM_EP-1:0] iso_ff;
	logic usb_clr;

	assign usb_clr = USB_BUS_RESET || force_rst_ff;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			oe_en_ff <= 1'b0;
			sof_en_ff <= 1'b0;
			lvd_dis_ff <= 1'b0;
			force_rst_ff <= `CTRL_FORCE_RESET;
		end else if (CE) begin
			if (wr_pend_ff && sel_cfg1) begin
				oe_en_ff <= HWDATA[`CFG1_OE_BIT];
			end
			if (wr_pend_ff && sel_cfg2) begin
				sof_en_ff <= HWDATA[`CFG2_SOF_BIT];
				// only a device reset takes the disable back
				if (HWDATA[`CFG2_LVD_BIT]) begin
					lvd_dis_ff <= 1'b1;
				end
			end
			if (wr_pend_ff && sel_ctrl) begin
				force_rst_ff <= HWDATA[`CTRL_FORCE_BIT];
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cep_ff <= '0;
			iso_ff <= '0;
		end else if (CE) begin
			if (wr_pend_ff && sel_cep) begin
				cep_ff <= HWDATA[NUM_EP-1:0];
			end
			if (wr_pend_ff && sel_iso) begin
				iso_ff <= HWDATA[NUM_EP-1:0];
			end
		end
	end

	// mirror content is undefined after reset, so no reset term
	always_ff @(posedge CORE_CLK) begin
		if (CE && wr_pend_ff && sel_mir_a) begin
			mir_a_ff <= HWDATA[7:0];
		end
		if (CE && wr_pend_ff && sel_mir_b) begin
			mir_b_ff <= HWDATA[7:0];
		end
	end

	// ****************************************
	// endpoint slots and routing
	// ****************************************
	reg8_t slot_q [NUM_EP];
	hs_t slot_ans [NUM_EP];
	logic [NUM_EP-1:0] slot_hit;
	logic [NUM_EP-1:0] slot_done;
	logic [NUM_EP-1:0] slot_take;
	logic [NUM_EP-1:0] ctr_ff;
	logic found;
	ep_num_t found_idx;

	// lowest numbered slot whose field matches takes the transaction
	always_comb begin
		found = 1'b0;
		found_idx = '0;
		for (int i = NUM_EP - 1; i >= 0; i--) begin
			if (slot_hit[i]) begin
				found = 1'b1;
				found_idx = ep_num_t'(i);
			end
		end
	end

	generate
		for (genvar g = 0; g < NUM_EP; g++) begin : g_slot
			assign slot_take[g] = RX_REQ && found && found_idx == ep_num_t'(g);
			endpoint_rx_slot u_slot (
				.clk(CORE_CLK),
				.rst(RST),
				.ce(CE),
				.usb_clr(usb_clr),
				.wr_en(wr_pend_ff && ep_sel && ep_addr == ep_num_t'(g)),
				.wr_data(HWDATA[7:0]),
				.take(slot_take[g]),
				.req_ep(RX_EP_NUM),
				.req_setup(RX_SETUP),
				.req_pid(RX_DATA_PID),
				.req_zero(RX_ZERO_LEN),
				.req_crc_ok(RX_CRC_OK),
				.cep(cep_ff[g]),
				.iso(iso_ff[g]),
				.ctr(ctr_ff[g]),
				.reg_q(slot_q[g]),
				.hit(slot_hit[g]),
				.answer(slot_ans[g]),
				.done(slot_done[g])
			);
			// flag survives usb reset; hardware set wins over software clear
			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					ctr_ff[g] <= 1'b0;
				end else if (CE) begin
					if (slot_take[g] && slot_done[g]) begin
						ctr_ff[g] <= 1'b1;
					end else if (wr_pend_ff && sel_ctr && HWDATA[g]) begin
						ctr_ff[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// transaction answer
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RX_ANS_VALID <= 1'b0;
			RX_ANS_CODE <= `HS_NONE;
			RX_ANS_HIT <= 1'b0;
			RX_ANS_SLOT <= '0;
			RX_ANS_BUF_SEL <= 1'b0;
		end else if (CE) begin
			RX_ANS_VALID <= RX_REQ;
			if (RX_REQ) begin
				RX_ANS_HIT <= found;
				RX_ANS_SLOT <= found_idx;
				RX_ANS_CODE <= found ? slot_ans[found_idx] : `HS_NONE;
				// buffer in use for the packet just taken
				RX_ANS_BUF_SEL <= slot_q[found_idx][`EPR_TOGGLE];
			end
		end
	end

	// ****************************************
	// pins: upstream enable, frame pulse, detector
	// ****************************************
	logic frame_pulse;
	logic lvd_s1_ff;
	logic lvd_s2_ff;

	frame_pulse_gen #(
		.FRAME_CYC(FRAME_CYC),
		.LEAD_CYC(FR_LEAD),
		.PULSE_CYC(FR_PULSE)
	) u_frame (
		.clk(CORE_CLK),
		.rst(RST),
		.ce(CE),
		.relock(usb_clr || USB_RESUME),
		.sof_seen(SOF_RECEIVED),
		.suspend(TIMER_SUSPEND_FLAG),
		.pulse(frame_pulse)
	);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			lvd_s1_ff <= 1'b0;
			lvd_s2_ff <= 1'b0;
		end else if (CE) begin
			lvd_s1_ff <= LOW_VOLTAGE_DETECTOR;
			lvd_s2_ff <= lvd_s1_ff;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			UPSTREAM_OUTPUT_ENABLE_PIN <= 1'b0;
			UPSTREAM_OUTPUT_ENABLE_PIN_OE <= 1'b0;
			FRAME_START_PULSE_OUT <= 1'b0;
			FRAME_START_PULSE_OUT_OE <= 1'b0;
			DEVICE_RESET_REQ <= 1'b0;
		end else if (CE) begin
			UPSTREAM_OUTPUT_ENABLE_PIN <= oe_en_ff && USB_OE_INTERNAL;
			UPSTREAM_OUTPUT_ENABLE_PIN_OE <= oe_en_ff;
			FRAME_START_PULSE_OUT <= sof_en_ff && frame_pulse;
			FRAME_START_PULSE_OUT_OE <= sof_en_ff;
			DEVICE_RESET_REQ <= lvd_s2_ff && !lvd_dis_ff;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	reg8_t ep_rd;
	reg8_t cfg1_rd;

	assign ep_rd = slot_q[ep_addr];
	assign cfg1_rd = `CFG1_FIXED_ONES | (8'(oe_en_ff) << `CFG1_OE_BIT);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			hrdata_ff <= 32'h0;
		end else if (CE) begin
			if (rd_pend_ff) begin
				if (ep_sel) begin
					hrdata_ff <= {24'h0, ep_rd};
				end else if (sel_cfg1) begin
					hrdata_ff <= {24'h0, cfg1_rd};
				end else if (sel_cfg2) begin
					hrdata_ff <= {30'h0, lvd_dis_ff, sof_en_ff};
				end else if (sel_mir_a) begin
					hrdata_ff <= {24'h0, reg8_t'({<<{mir_a_ff}})};
				end else if (sel_mir_b) begin
					hrdata_ff <= {24'h0, reg8_t'({<<{mir_b_ff}})};
				end else if (sel_ctr) begin
					hrdata_ff <= 32'(ctr_ff);
				end else if (sel_cep) begin
					hrdata_ff <= 32'(cep_ff);
				end else if (sel_iso) begin
					hrdata_ff <= 32'(iso_ff);
				end else if (sel_ctrl) begin
					hrdata_ff <= {25'h0, TIMER_SUSPEND_FLAG, 5'h0, force_rst_ff};
				end else begin
					hrdata_ff <= 32'h0;
				end
			end
		end
	end

	assign HRDATA = hrdata_ff;
	assign HREADYOUT = hready_ff;
	assign HRESP = 1'b0;
endmodule : usb_endpoint_rx_control
`default_nettype wire

/* File: hw/usb_rx_params.svh */
// offsets, field positions, reset values and timing counts of the receive control block
//
// Operation
// - endpoint registers clear on any reset
// - sixteen endpoint receive registers, ids 0-15
// - status-out set: data-carrying OUT gets STALL
// - status-out clear: OUT of any length
// - non-iso toggle inverts on ACK of match
// - control endpoint SETUP clears the toggle
// - iso toggle swaps buffer after each correct packet
// - state: ignore, STALL, NAK, receive
// - correct OUT/SETUP sets state to NAK
// - iso endpoints keep state after success
// - route by endpoint number field match
// - config one resets 0Fh, low nibble ones
// - oe bit gates upstream output enable pin
// - detector disable is set-only, device reset clears
// - detector resets device only when enabled
// - 333.33 ns pulse ten bits before SOF
// - pulse after two SOFs, stops on suspend
// - frame pulse enable gates output, resets zero
// - mirror A reads back bit-reversed
// - mirror B reads back bit-reversed, independent
// - correct transfer flag set by hardware, cleared by software
`ifndef USB_RX_PARAMS_SVH
`define USB_RX_PARAMS_SVH

// ****************************************
// register indexes, byte address = {page, index} * 4
// ****************************************
`define EP_PAGE_LO 8'h04
`define EP_PAGE_HI 8'h05
`define EP_RX_IDX_FIRST 8'hf1
`define EP_RX_IDX_STEP 8'h02
`define CFG_PAGE 8'h3c
`define DEV_CFG1_IDX 8'hf4
`define DEV_CFG2_IDX 8'hf5
`define MIRROR_A_IDX 8'hf6
`define MIRROR_B_IDX 8'hf7
`define OWN_PAGE 8'h00
`define CTR_FLAG_IDX 8'h00
`define CEP_MASK_IDX 8'h01
`define ISO_MASK_IDX 8'h02
`define USB_CTRL_IDX 8'h03

// ****************************************
// fields and reset values
// ****************************************
`define EPR_STATUS_OUT 7
`define EPR_TOGGLE 6
`define EPR_STATE_HI 5
`define EPR_STATE_LO 4
`define EP_RX_RESET 8'h00
`define CFG1_RESET 8'h0f
`define CFG1_FIXED_ONES 8'h0f
`define CFG1_OE_BIT 5
`define CFG2_LVD_BIT 1
`define CFG2_SOF_BIT 0
`define CTRL_FORCE_BIT 0
`define CTRL_SUSP_BIT 6
`define CTRL_FORCE_RESET 1'b1

// receive states and handshake answers
`define RXS_DISABLED 2'h0
`define RXS_STALL 2'h1
`define RXS_NAK 2'h2
`define RXS_VALID 2'h3
`define HS_NONE 2'h0
`define HS_STALL 2'h1
`define HS_NAK 2'h2
`define HS_ACK 2'h3

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 40
`define FRAME_NS 1000000
`define FRAME_PULSE_PS 333330
`define USB_BIT_PS 83333
`define SOF_LEAD_BITS 10
`define FRAME_CYC ((`FRAME_NS * `CLK_MHZ) / 1000)
`define PULSE_CYC ((`FRAME_PULSE_PS * `CLK_MHZ + 999999) / 1000000)
`define LEAD_CYC ((`SOF_LEAD_BITS * `USB_BIT_PS * `CLK_MHZ) / 1000000)

`endif

/* File: hw/usb_rx_pkg.sv */
// types shared by the receive control block
package usb_rx_pkg;
	typedef logic [1:0] hs_t;
	typedef logic [3:0] ep_num_t;
	typedef logic [7:0] reg8_t;
endpackage : usb_rx_pkg

/* File: hw/endpoint_rx_slot.sv */
// one endpoint receive control register with its transaction decision
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_params.svh"
module endpoint_rx_slot
	import usb_rx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic usb_clr,
	input wire logic wr_en,
	input wire usb_rx_pkg::reg8_t wr_data,
	input wire logic take,
	input wire usb_rx_pkg::ep_num_t req_ep,
	input wire logic req_setup,
	input wire logic req_pid,
	input wire logic req_zero,
	input wire logic req_crc_ok,
	input wire logic cep,
	input wire logic iso,
	input wire logic ctr,
	output usb_rx_pkg::reg8_t reg_q,
	output logic hit,
	output usb_rx_pkg::hs_t answer,
	output logic done
);
	import usb_rx_pkg::*;

	reg8_t epr_ff;
	reg8_t nxt_epr;
	logic [1:0] st;
	logic tog;

	assign reg_q = epr_ff;
	assign st = epr_ff[`EPR_STATE_HI:`EPR_STATE_LO];
	assign tog = epr_ff[`EPR_TOGGLE];
	assign hit = (epr_ff[3:0] == req_ep);

	always_comb begin
		answer = `HS_NONE;
		done = 1'b0;
		nxt_epr = epr_ff;
		if (req_setup) begin
			// nak-state control endpoint stays silent on setup
			if (cep && req_crc_ok && (st == `RXS_VALID || st == `RXS_STALL)) begin
				answer = `HS_ACK;
				done = 1'b1;
				nxt_epr[`EPR_TOGGLE] = 1'b1; // cleared, then data0 acked
				nxt_epr[`EPR_STATE_HI:`EPR_STATE_LO] = `RXS_NAK;
			end
		end else if (iso) begin
			if (st == `RXS_VALID && req_crc_ok) begin
				done = 1'b1;
				nxt_epr[`EPR_TOGGLE] = ~tog;
			end
		end else begin
			case (st)
				`RXS_DISABLED: answer = `HS_NONE;
				`RXS_STALL: answer = `HS_STALL;
				`RXS_NAK: answer = `HS_NAK;
				default: begin
					if (ctr) begin
						answer = `HS_NAK;
					end else if (epr_ff[`EPR_STATUS_OUT] && !req_zero) begin
						answer = `HS_STALL;
					end else if (!req_crc_ok) begin
						answer = `HS_NONE;
					end else if (req_pid == tog) begin
						answer = `HS_ACK;
						done = 1'b1;
						nxt_epr[`EPR_TOGGLE] = ~tog;
						nxt_epr[`EPR_STATE_HI:`EPR_STATE_LO] = `RXS_NAK;
					end else begin
						// repeated packet: acknowledge, keep nothing
						answer = `HS_ACK;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			epr_ff <= `EP_RX_RESET;
		end else if (ce) begin
			if (usb_clr) begin
				epr_ff <= `EP_RX_RESET;
			end else if (take) begin
				epr_ff <= nxt_epr;
			end else if (wr_en) begin
				epr_ff <= wr_data;
			end
		end
	end
endmodule : endpoint_rx_slot
`default_nettype wire

/* File: hw/frame_pulse_gen.sv */
// frame timer lock and start-of-frame lead pulse
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_params.svh"
module frame_pulse_gen #(
	parameter int FRAME_CYC = 40000,
	parameter int LEAD_CYC = 33,
	parameter int PULSE_CYC = 14
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic relock,
	input wire logic sof_seen,
	input wire logic suspend,
	output logic pulse
);
	localparam int CW = $clog2(FRAME_CYC + 1);
	localparam logic [CW-1:0] FIRE_AT = CW'(FRAME_CYC - LEAD_CYC);
	localparam logic [CW-1:0] FRAME_MAX = CW'(FRAME_CYC);
	localparam logic [4:0] PULSE_LEN = 5'(PULSE_CYC);

	logic [CW-1:0] cnt_ff;
	logic [1:0] sofs_ff;
	logic [4:0] width_ff;
	logic locked;

	assign locked = (sofs_ff == 2'h2);

	// ****************************************
	// lock on the second SOF, drop on reset, resume or suspend
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sofs_ff <= 2'h0;
		end else if (ce) begin
			if (relock || suspend) begin
				sofs_ff <= 2'h0;
			end else if (sof_seen && !locked) begin
				sofs_ff <= sofs_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (ce) begin
			if (sof_seen) begin
				cnt_ff <= '0;
			end else if (cnt_ff != FRAME_MAX) begin
				cnt_ff <= cnt_ff + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			width_ff <= 5'h0;
		end else if (ce) begin
			if (suspend || !locked) begin
				width_ff <= 5'h0;
			end else if (cnt_ff == FIRE_AT && !sof_seen) begin
				width_ff <= PULSE_LEN;
			end else if (width_ff != 5'h0) begin
				width_ff <= width_ff - 5'h1;
			end
		end
	end

	assign pulse = (width_ff != 5'h0);
endmodule : frame_pulse_gen
`default_nettype wire

/* File: dv/usb_rx_checker.sv */
// port assertions of the receive control block
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_params.svh"
module usb_rx_checker
	import usb_rx_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic USB_BUS_RESET,
	input wire logic RX_REQ,
	input wire logic RX_ANS_VALID,
	input wire usb_rx_pkg::hs_t RX_ANS_CODE,
	input wire logic RX_ANS_HIT,
	input wire logic USB_OE_INTERNAL,
	input wire logic UPSTREAM_OUTPUT_ENABLE_PIN,
	input wire logic UPSTREAM_OUTPUT_ENABLE_PIN_OE,
	input wire logic FRAME_START_PULSE_OUT,
	input wire logic FRAME_START_PULSE_OUT_OE,
	input wire logic TIMER_SUSPEND_FLAG,
	input wire logic LOW_VOLTAGE_DETECTOR,
	input wire logic DEVICE_RESET_REQ
);
	logic [7:0] run_ff;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// length of the current frame pulse
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			run_ff <= 8'h00;
		else
			run_ff <= FRAME_START_PULSE_OUT ? run_ff + 8'h01 : 8'h00;
	end
	a_ans_paired:
	assert property (RX_ANS_VALID == $past(RX_REQ)) else $error("answer not one cycle after request");
	a_miss_silent:
	assert property (RX_ANS_VALID && !RX_ANS_HIT |-> RX_ANS_CODE == `HS_NONE)
		else $error("unmatched packet answered");
	a_reset_ignore:
	assert property (USB_BUS_RESET && $past(USB_BUS_RESET) && RX_REQ |=> RX_ANS_CODE == `HS_NONE)
		else $error("packet answered during bus reset");
	a_oe_pin_gated:
	assert property (UPSTREAM_OUTPUT_ENABLE_PIN ==
		(UPSTREAM_OUTPUT_ENABLE_PIN_OE && $past(USB_OE_INTERNAL))) else $error("upstream oe pin wrong");
	a_pulse_gated:
	assert property (FRAME_START_PULSE_OUT |-> FRAME_START_PULSE_OUT_OE)
		else $error("frame pulse while output disabled");
	a_pulse_length:
	assert property ($fell(FRAME_START_PULSE_OUT) && !TIMER_SUSPEND_FLAG && FRAME_START_PULSE_OUT_OE
		|-> run_ff == 8'h0e) else $error("frame pulse length wrong");
	a_pulse_suspend:
	assert property (TIMER_SUSPEND_FLAG [*3] |-> !FRAME_START_PULSE_OUT)
		else $error("frame pulse during suspend");
	a_lvd_gate:
	assert property (DEVICE_RESET_REQ |-> $past(LOW_VOLTAGE_DETECTOR, 3))
		else $error("device reset without low supply");
endmodule : usb_rx_checker
bind usb_endpoint_rx_control usb_rx_checker chk (.CORE_CLK(CORE_CLK), .RST(RST),
	.USB_BUS_RESET(USB_BUS_RESET), .RX_REQ(RX_REQ), .RX_ANS_VALID(RX_ANS_VALID),
	.RX_ANS_CODE(RX_ANS_CODE), .RX_ANS_HIT(RX_ANS_HIT), .USB_OE_INTERNAL(USB_OE_INTERNAL),
	.UPSTREAM_OUTPUT_ENABLE_PIN(UPSTREAM_OUTPUT_ENABLE_PIN),
	.UPSTREAM_OUTPUT_ENABLE_PIN_OE(UPSTREAM_OUTPUT_ENABLE_PIN_OE),
	.FRAME_START_PULSE_OUT(FRAME_START_PULSE_OUT), .FRAME_START_PULSE_OUT_OE(FRAME_START_PULSE_OUT_OE),
	.TIMER_SUSPEND_FLAG(TIMER_SUSPEND_FLAG), .LOW_VOLTAGE_DETECTOR(LOW_VOLTAGE_DETECTOR),
	.DEVICE_RESET_REQ(DEVICE_RESET_REQ));
`default_nettype wire

/* File: dv/usb_host_model.sv */
// upstream host model issuing OUT and SETUP packets
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
	import usb_rx_pkg::*;
(
	input wire logic clk,
	input wire logic ans_valid,
	output logic req,
	output usb_rx_pkg::ep_num_t ep,
	output logic [3:0] fld
);
	initial begin
		req = 1'b0;
		ep = 4'h0;
		fld = 4'h0;
	end
	// fld is {setup, data pid, zero length, crc ok}; lines garbled outside the packet
	task automatic send(input ep_num_t e, input logic [3:0] f, output logic ok);
		int i;
		@(posedge clk);
		req <= 1'b1;
		ep <= e;
		fld <= f;
		@(posedge clk);
		req <= 1'b0;
		ep <= ~e;
		fld <= ~f;
		ok = 1'b0;
		for (i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			ok = (ans_valid === 1'b1);
		end
	endtask : send
endmodule : usb_host_model
`default_nettype wire

/* File: dv/tb.sv */
// register and transaction tests of the receive control block
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_params.svh"
module tb;
	import usb_rx_pkg::*;
	localparam int FC = 200;
	// {reg in, setup pid zero crc, cep iso, answer, reg out, transfer flag}
	localparam logic [24:0] TBL [13] = '{
		{8'h09, 4'b0001, 2'b00, `HS_NONE, 8'h09, 1'b0}, {8'h19, 4'b0001, 2'b00, `HS_STALL, 8'h19, 1'b0},
		{8'h29, 4'b0001, 2'b00, `HS_NAK, 8'h29, 1'b0}, {8'h39, 4'b0001, 2'b00, `HS_ACK, 8'h69, 1'b1},
		{8'h39, 4'b0101, 2'b00, `HS_ACK, 8'h39, 1'b0}, {8'h39, 4'b0000, 2'b00, `HS_NONE, 8'h39, 1'b0},
		{8'hb9, 4'b0001, 2'b00, `HS_STALL, 8'hb9, 1'b0}, {8'hb9, 4'b0011, 2'b00, `HS_ACK, 8'he9, 1'b1},
		{8'h59, 4'b1001, 2'b10, `HS_ACK, 8'h69, 1'b1}, {8'h29, 4'b1001, 2'b10, `HS_NONE, 8'h29, 1'b0},
		{8'h39, 4'b1001, 2'b00, `HS_NONE, 8'h39, 1'b0}, {8'h39, 4'b0001, 2'b01, `HS_NONE, 8'h79, 1'b1},
		{8'h79, 4'b0101, 2'b01, `HS_NONE, 8'h39, 1'b1}};
	logic clk, rst, hsel, hwrite, ureset, resume, sof, susp, oe_int, low_voltage_detector, hreadyout, hresp, ce;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic rx_req, ans_valid, rx_hit, buf_sel, oe_pin, oe_en, fpo, fpo_oe, dev_rst, ok;
	logic [3:0] rx_fld;
	ep_num_t rx_ep, rx_slot;
	hs_t rx_code;
	int failures, n_tests;
	usb_endpoint_rx_control #(.NUM_EP(16), .FRAME_CYC(FC)) dut (.CORE_CLK(clk), .RST(rst), .CE(ce),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.USB_BUS_RESET(ureset), .USB_RESUME(resume), .SOF_RECEIVED(sof), .TIMER_SUSPEND_FLAG(susp),
		.RX_REQ(rx_req), .RX_EP_NUM(rx_ep), .RX_SETUP(rx_fld[3]), .RX_DATA_PID(rx_fld[2]),
		.RX_ZERO_LEN(rx_fld[1]), .RX_CRC_OK(rx_fld[0]), .RX_ANS_VALID(ans_valid),
		.RX_ANS_CODE(rx_code), .RX_ANS_HIT(rx_hit), .RX_ANS_SLOT(rx_slot), .RX_ANS_BUF_SEL(buf_sel),
		.USB_OE_INTERNAL(oe_int), .UPSTREAM_OUTPUT_ENABLE_PIN(oe_pin),
		.UPSTREAM_OUTPUT_ENABLE_PIN_OE(oe_en), .FRAME_START_PULSE_OUT(fpo),
		.FRAME_START_PULSE_OUT_OE(fpo_oe), .LOW_VOLTAGE_DETECTOR(low_voltage_detector), .DEVICE_RESET_REQ(dev_rst));
	usb_host_model host (.clk(clk), .ans_valid(ans_valid), .req(rx_req), .ep(rx_ep), .fld(rx_fld));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] ep_a(int n);
		return {16'h0, (n < 8) ? `EP_PAGE_LO : `EP_PAGE_HI, `EP_RX_IDX_FIRST + 8'(2 * (n % 8))} << 2;
	endfunction : ep_a
	task automatic report_and_stop();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
			failures++;
		end
	endtask : chk
	task automatic wait_rdy();
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (hreadyout === 1'b1)
				return;
		end
		$display("[FAIL] %0t bus ready timeout", $time);
		failures++;
		report_and_stop();
	endtask : wait_rdy
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
	endtask : ahb
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rc
	// one frame of FC cycles opened by a received start of frame
	task automatic frame(output int hi, output int first);
		int i;
		hi = 0;
		first = -1;
		for (i = 0; i < FC; i++) begin
			@(posedge clk);
			sof <= (i == 0);
			if (fpo === 1'b1) begin
				if (first < 0)
					first = i;
				hi++;
			end
		end
	endtask : frame
	initial begin
		repeat (100000) @(posedge clk);
		$display("[FAIL] %0t run timeout", $time);
		failures++;
		report_and_stop();
	end
	initial begin
		int k, hi, first;
		logic [24:0] e;
		{rst, hsel, hwrite, ureset, resume, sof, susp, oe_int, low_voltage_detector} = 9'h100;
		{haddr, hwdata, htrans} = 66'h0;
		ce = 1'b1;
		failures = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc(32'hf3d0, 32'h0f);
		rc(32'hf3d4, 32'h00);
		rc(ep_a(0), 32'h00);
		rc(32'hc, 32'h01);
		wr(32'hc, 32'h0);
		for (k = 0; k < 16; k++) begin
			wr(ep_a(k), 32'h20 | k);
			rc(ep_a(k), 32'h20 | k);
		end
		wr(32'hc, 32'h1);
		rc(ep_a(15), 32'h0);
		wr(32'hc, 32'h0);
		wr(ep_a(3), 32'h39);
		ureset <= 1'b1;
		repeat (2) @(posedge clk);
		host.send(4'h9, 4'b0001, ok);
		chk({30'h0, rx_code}, {30'h0, `HS_NONE});
		ureset <= 1'b0;
		rc(ep_a(3), 32'h0);
		host.send(4'h7, 4'b0001, ok);
		chk({31'h0, rx_hit}, 32'h0);
		for (k = 0; k < 13; k++) begin
			e = TBL[k];
			wr(32'h4, {28'h0, e[12], 3'h0});
			wr(32'h8, {28'h0, e[11], 3'h0});
			wr(ep_a(3), {24'h0, e[24:17]});
			host.send(4'h9, e[16:13], ok);
			chk({31'h0, ok}, 32'h1);
			chk({30'h0, rx_code}, {30'h0, e[10:9]});
			chk({27'h0, rx_hit, rx_slot}, 32'h13);
			chk({31'h0, buf_sel}, {31'h0, e[23]});
			rc(ep_a(3), {24'h0, e[8:1]});
			rc(32'h0, {28'h0, e[0], 3'h0});
			wr(32'h0, 32'hffff);
		end
		wr(32'h40000, 32'hff);
		rc(32'h40000, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		wr(32'hf3d8, 32'h01);
		wr(32'hf3dc, 32'hc5);
		rc(32'hf3d8, 32'h80);
		rc(32'hf3dc, 32'ha3);
		ce <= 1'b0;
		wr(32'hf3d8, 32'hff);
		ce <= 1'b1;
		rc(32'hf3d8, 32'h80);
		oe_int <= 1'b1;
		wr(32'hf3d0, 32'hff);
		rc(32'hf3d0, 32'h2f);
		chk({30'h0, oe_en, oe_pin}, 32'h3);
		wr(32'hf3d0, 32'h0);
		repeat (2) @(posedge clk);
		chk({30'h0, oe_en, oe_pin}, 32'h0);
		low_voltage_detector <= 1'b1;
		repeat (5) @(posedge clk);
		chk({31'h0, dev_rst}, 32'h1);
		wr(32'hf3d4, 32'h03);
		wr(32'hf3d4, 32'h01);
		rc(32'hf3d4, 32'h03);
		chk({31'h0, dev_rst}, 32'h0);
		chk({31'h0, fpo_oe}, 32'h1);
		low_voltage_detector <= 1'b0;
		for (k = 0; k < 7; k++) begin
			susp <= (k == 3);
			resume <= (k == 4);
			frame(hi, first);
			chk(hi, (k == 1 || k == 2 || k == 6) ? 14 : 0);
			if (k == 1)
				chk({31'h0, first >= FC - 36 && first <= FC - 26}, 32'h1);
		end
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
